// ### hdl/hscci_top.v
// Command and response word interface of a two-channel counter module
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
`include "hscci_regs.vh"
module hscci_top #(
  parameter DW = 16,
  parameter VW = 32
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Register port
  input wire [3:0] reg_addr,
  input wire [DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [DW-1:0] reg_rdata_ff,
  // Controller scan and run state
  input wire scan_strobe,
  input wire plc_run,
  input wire bus_ok,
  input wire [DW-1:0] ofl_cfg1,
  input wire [DW-1:0] ofl_cfg2,
  // Field pins
  input wire [1:0] hw_preset,
  input wire [1:0] hw_enable,
  input wire field_pwr_ok,
  // Values from the counting datapath
  input wire [VW-1:0] cnt1_val,
  input wire [VW-1:0] cnt2_val,
  input wire [VW-1:0] rate1_val,
  input wire [VW-1:0] rate2_val,
  input wire [VW-1:0] last1_val,
  input wire [VW-1:0] last2_val,
  // Controls to the counting datapath
  output reg [1:0] cnt_en_ff,
  output reg [1:0] preset_ff,
  output reg quad_ff,
  output reg [1:0] mode_ff,
  output reg assert_en_ff,
  output reg loss_hold_ff,
  output reg [DW-1:0] out_mode_ff,
  output reg outputs_off_ff,
  output reg pwr_lost_ff,
  // Loaded parameters
  output reg [VW-1:0] max1_ff,
  output reg [VW-1:0] set1_ff,
  output reg [VW-1:0] max2_ff,
  output reg [VW-1:0] set2_ff,
  output reg [`HSCCI_TIME_W-1:0] on_time_ff,
  output reg [`HSCCI_TIME_W-1:0] rint1_ff,
  output reg [`HSCCI_TIME_W-1:0] rint2_ff
);

  // Command words as written, responses as last built
  reg [DW-1:0] cmd_ff [0:`HSCCI_NWORDS-1];
  reg [DW-1:0] rsp_ff [0:`HSCCI_NWORDS-1];
  reg [DW-1:0] nxt_rsp [0:`HSCCI_NWORDS-1];
  // Software enable state per channel
  reg [1:0] sw_en_ff;
  // Source of the latest preset, 1 = pin
  reg [1:0] pre_src_ff;
  // Previous synchronised preset pins, for edge detection
  reg [1:0] hw_pre_q_ff;
  // Previous run state, to catch the start of run
  reg run_q_ff;
  // Synchronised pins
  wire [4:0] pin_sync;
  wire [1:0] hw_pre_s;
  wire [1:0] hw_en_s;
  wire pwr_s;
  // Word 0 decoding, preset pin edges and run start
  wire [7:0] code;
  wire [DW-1:0] w0;
  wire [1:0] hw_pre_edge;
  wire [1:0] sw_pre;
  wire run_start;
  // Configure source: command words on a configure scan, else offline words at run start
  wire cfg_now;
  wire [DW-1:0] cfg1_src;
  wire [DW-1:0] cfg2_src;
  wire [1:0] cfg_mode;
  wire load_now;
  // Output modes after timed-output resolution
  reg [DW-1:0] nxt_out_mode;
  reg timed_seen;
  reg [3:0] nib;
  integer k;
  // Separate loop index for the response builder, one driver each
  integer kr;
  genvar g;

  // Pins pass two flops before any logic sees them
  hscci_sync #(
    .W(5)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({field_pwr_ok, hw_enable, hw_preset}),
    .sync_out(pin_sync)
  );

  assign hw_pre_s = pin_sync[1:0];
  assign hw_en_s = pin_sync[3:2];
  assign pwr_s = pin_sync[4];

  assign w0 = cmd_ff[0];
  // Code byte sits beside the channel controls
  assign code = w0[`HSCCI_CODE_HI:`HSCCI_CODE_LO];
  assign hw_pre_edge = hw_pre_s & ~hw_pre_q_ff;
  assign sw_pre = {w0[`HSCCI_B_PRE2], w0[`HSCCI_B_PRE1]} &
                  {2{scan_strobe}};
  assign run_start = plc_run & ~run_q_ff;
  // Command configure wins over offline words in the same cycle
  assign cfg_now = run_start |
                   (scan_strobe && code == `HSCCI_CODE_CFG);
  assign cfg1_src = (scan_strobe && code == `HSCCI_CODE_CFG) ?
                    cmd_ff[1] : ofl_cfg1;
  assign cfg2_src = (scan_strobe && code == `HSCCI_CODE_CFG) ?
                    cmd_ff[2] : ofl_cfg2;
  assign cfg_mode = cfg1_src[`HSCCI_MODE_HI:`HSCCI_MODE_LO];
  assign load_now = scan_strobe && code == `HSCCI_CODE_LOAD;

  // Command words, one per generate entry
  generate
    for (g = 0; g < `HSCCI_NWORDS; g = g + 1)
    begin : g_cmd
      always @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          cmd_ff[g] <= `HSCCI_WORD_RST;
        else if (reg_wr && !reg_addr[`HSCCI_RSP_SEL_BIT] &&
                 reg_addr[2:0] == g)
          cmd_ff[g] <= reg_wdata;
      end
    end
  endgenerate

  // Register read: data stand one cycle, unmapped reads give zero
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_ff <= `HSCCI_WORD_RST;
    else if (reg_rd && reg_addr[2:0] <= `HSCCI_IDX_LAST)
    begin
      // Bit 3 selects the response bank
      if (reg_addr[`HSCCI_RSP_SEL_BIT])
        reg_rdata_ff <= rsp_ff[reg_addr[2:0]];
      else
        reg_rdata_ff <= cmd_ff[reg_addr[2:0]];
    end
    else
      reg_rdata_ff <= `HSCCI_WORD_RST;
  end

  // Keep only the first output set to a timed mode
  always @*
  begin
    nxt_out_mode = cfg2_src;
    timed_seen = 1'b0;
    nib = `HSCCI_OUT_OFF;
    // Nibble 3 (output 1A) is scanned first
    for (k = 3; k >= 0; k = k - 1)
    begin
      nib = cfg2_src[k*4 +: 4];
      if (nib == `HSCCI_OUT_TIMED_A || nib == `HSCCI_OUT_TIMED_B)
      begin
        if (timed_seen)
          nxt_out_mode[k*4 +: 4] = `HSCCI_OUT_OFF;
        timed_seen = 1'b1;
      end
    end
  end

  // Channel enables and presets; command bits acted on once per scan, pins every cycle
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_en_ff <= 2'h3;
      cnt_en_ff <= 2'h0;
      preset_ff <= 2'h0;
      pre_src_ff <= 2'h0;
      hw_pre_q_ff <= 2'h0;
      run_q_ff <= 1'b0;
    end
    else
    begin
      hw_pre_q_ff <= hw_pre_s;
      run_q_ff <= plc_run;
      if (scan_strobe)
      begin
        // Disable wins if both bits are set
        if (w0[`HSCCI_B_DIS1])
          sw_en_ff[0] <= 1'b0;
        else if (w0[`HSCCI_B_EN1])
          sw_en_ff[0] <= 1'b1;
        if (w0[`HSCCI_B_DIS2])
          sw_en_ff[1] <= 1'b0;
        else if (w0[`HSCCI_B_EN2])
          sw_en_ff[1] <= 1'b1;
      end
      // Either source alone can stop counting
      cnt_en_ff <= sw_en_ff & hw_en_s;
      // Each preset reloads the counter, so the latest one sticks
      preset_ff <= hw_pre_edge | sw_pre;
      // Pin wins only if both arrive in one cycle
      if (hw_pre_edge[0])
        pre_src_ff[0] <= 1'b1;
      else if (sw_pre[0])
        pre_src_ff[0] <= 1'b0;
      if (hw_pre_edge[1])
        pre_src_ff[1] <= 1'b1;
      else if (sw_pre[1])
        pre_src_ff[1] <= 1'b0;
    end
  end

  // Configuration, from offline words at run start or command 1
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quad_ff <= 1'b0;
      mode_ff <= `HSCCI_MODE_TWO16;
      assert_en_ff <= 1'b0;
      loss_hold_ff <= 1'b0;
      out_mode_ff <= `HSCCI_WORD_RST;
    end
    else if (cfg_now)
    begin
      // Pulse or quadrature inputs
      quad_ff <= cfg1_src[`HSCCI_B_QUAD];
      // One mode field for both channels
      mode_ff <= cfg_mode;
      // Assertion is blocked in two-32 and rate layouts
      assert_en_ff <= !cfg1_src[`HSCCI_B_ASSERT_OFF] &&
                      (cfg_mode == `HSCCI_MODE_TWO16 ||
                       cfg_mode == `HSCCI_MODE_ONE32);
      loss_hold_ff <= cfg1_src[`HSCCI_B_LOSS_HOLD];
      out_mode_ff <= nxt_out_mode;
    end
  end

  // Outputs off on bus loss unless configured to hold
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outputs_off_ff <= 1'b1;
      pwr_lost_ff <= 1'b0;
    end
    else
    begin
      outputs_off_ff <= !assert_en_ff || (!bus_ok && !loss_hold_ff);
      pwr_lost_ff <= !pwr_s;
    end
  end

  // Load values; format follows the configured mode
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      max1_ff <= `HSCCI_VAL_RST;
      set1_ff <= `HSCCI_VAL_RST;
      max2_ff <= `HSCCI_VAL_RST;
      set2_ff <= `HSCCI_VAL_RST;
      on_time_ff <= `HSCCI_TIME_RST;
      rint1_ff <= `HSCCI_TIME_RST;
      rint2_ff <= `HSCCI_TIME_RST;
    end
    else if (load_now)
    begin
      // Zero words and zero pairs change nothing
      case (mode_ff)
        `HSCCI_MODE_TWO16:
        begin
          if (cmd_ff[1] != 0)
            max1_ff <= {{(VW-DW){1'b0}}, cmd_ff[1]};
          if (cmd_ff[2] != 0)
            set1_ff <= {{(VW-DW){1'b0}}, cmd_ff[2]};
          if (cmd_ff[3] != 0)
            max2_ff <= {{(VW-DW){1'b0}}, cmd_ff[3]};
          if (cmd_ff[4] != 0)
            set2_ff <= {{(VW-DW){1'b0}}, cmd_ff[4]};
          if (cmd_ff[5] != 0)
            on_time_ff <= cmd_ff[5][`HSCCI_TIME_W-1:0];
        end
        `HSCCI_MODE_ONE32:
        begin
          // Low word first, high word second
          if ({cmd_ff[2], cmd_ff[1]} != 0)
            max1_ff <= {cmd_ff[2], cmd_ff[1]};
          if ({cmd_ff[4], cmd_ff[3]} != 0)
            set1_ff <= {cmd_ff[4], cmd_ff[3]};
          if (cmd_ff[5] != 0)
            on_time_ff <= cmd_ff[5][`HSCCI_TIME_W-1:0];
        end
        `HSCCI_MODE_TWO32:
        begin
          if ({cmd_ff[2], cmd_ff[1]} != 0)
            max1_ff <= {cmd_ff[2], cmd_ff[1]};
          if ({cmd_ff[4], cmd_ff[3]} != 0)
            max2_ff <= {cmd_ff[4], cmd_ff[3]};
        end
        default:
        begin
          // Rate-sample intervals in milliseconds
          if (cmd_ff[1] != 0)
            rint1_ff <= cmd_ff[1][`HSCCI_TIME_W-1:0];
          if (cmd_ff[2] != 0)
            rint2_ff <= cmd_ff[2][`HSCCI_TIME_W-1:0];
        end
      endcase
    end
  end

  // Build all six responses from one snapshot
  always @*
  begin
    for (kr = 0; kr < `HSCCI_NWORDS; kr = kr + 1)
      nxt_rsp[kr] = cmd_ff[kr];
    case (code)
      `HSCCI_CODE_CFG, `HSCCI_CODE_LOAD:
      begin
        // Same echo layout for both
        for (kr = 0; kr < `HSCCI_NWORDS; kr = kr + 1)
          nxt_rsp[kr] = cmd_ff[kr];
      end
      `HSCCI_CODE_READ:
      begin
        // Only word 0 is read from the command side
        nxt_rsp[1] = cnt1_val[DW-1:0];
        nxt_rsp[2] = cnt1_val[VW-1:DW];
        nxt_rsp[3] = cnt2_val[DW-1:0];
        nxt_rsp[4] = cnt2_val[VW-1:DW];
      end
      `HSCCI_CODE_RATE:
      begin
        // Rate data in rate mode, else count before preset
        if (mode_ff == `HSCCI_MODE_RATE)
        begin
          nxt_rsp[1] = rate1_val[DW-1:0];
          nxt_rsp[2] = rate1_val[VW-1:DW];
          nxt_rsp[3] = rate2_val[DW-1:0];
          nxt_rsp[4] = rate2_val[VW-1:DW];
        end
        else
        begin
          nxt_rsp[1] = last1_val[DW-1:0];
          nxt_rsp[2] = last1_val[VW-1:DW];
          nxt_rsp[3] = last2_val[DW-1:0];
          nxt_rsp[4] = last2_val[VW-1:DW];
        end
      end
      default:
      begin
        // Code 0 and unknown codes track the mode
        if (mode_ff == `HSCCI_MODE_RATE)
        begin
          nxt_rsp[1] = rate1_val[DW-1:0];
          nxt_rsp[2] = rate1_val[VW-1:DW];
          nxt_rsp[3] = rate2_val[DW-1:0];
          nxt_rsp[4] = rate2_val[VW-1:DW];
        end
        else
        begin
          nxt_rsp[1] = cnt1_val[DW-1:0];
          nxt_rsp[2] = cnt1_val[VW-1:DW];
          nxt_rsp[3] = cnt2_val[DW-1:0];
          nxt_rsp[4] = cnt2_val[VW-1:DW];
        end
      end
    endcase
    // Data responses carry a status word last
    if (code != `HSCCI_CODE_CFG && code != `HSCCI_CODE_LOAD)
    begin
      nxt_rsp[5] = `HSCCI_WORD_RST;
      nxt_rsp[5][`HSCCI_B_STAT_PWR] = pwr_lost_ff;
      nxt_rsp[5][`HSCCI_B_STAT_SRC1] = pre_src_ff[0];
      nxt_rsp[5][`HSCCI_B_STAT_SRC2] = pre_src_ff[1];
    end
  end

  // Responses change only on a scan, all six at once
  generate
    for (g = 0; g < `HSCCI_NWORDS; g = g + 1)
    begin : g_rsp
      always @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          rsp_ff[g] <= `HSCCI_WORD_RST;
        else if (scan_strobe)
          rsp_ff[g] <= nxt_rsp[g];
      end
    end
  endgenerate

endmodule

// ### hdl/hscci_regs.vh
// Offsets, field positions, codes and reset values of the counter interface
`ifndef HSCCI_REGS_VH
`define HSCCI_REGS_VH

// Register port map: command words at 0..5, response words at 8..13
`define HSCCI_NWORDS 6
`define HSCCI_RSP_SEL_BIT 3
`define HSCCI_IDX_LAST 3'h5

// Command code byte in word 0
`define HSCCI_CODE_HI 15
`define HSCCI_CODE_LO 8
`define HSCCI_CODE_CFG 8'h01
`define HSCCI_CODE_LOAD 8'h02
`define HSCCI_CODE_READ 8'h03
`define HSCCI_CODE_RATE 8'h04

// Channel control bits in word 0
`define HSCCI_B_PRE1 0
`define HSCCI_B_EN1 1
`define HSCCI_B_DIS1 2
`define HSCCI_B_PRE2 4
`define HSCCI_B_EN2 5
`define HSCCI_B_DIS2 6

// Configure word 1 fields
`define HSCCI_B_QUAD 0
`define HSCCI_B_ASSERT_OFF 1
`define HSCCI_B_LOSS_HOLD 2
`define HSCCI_MODE_HI 11
`define HSCCI_MODE_LO 10

// Counter / rate-sample layouts
`define HSCCI_MODE_TWO16 2'h0
`define HSCCI_MODE_ONE32 2'h1
`define HSCCI_MODE_TWO32 2'h2
`define HSCCI_MODE_RATE 2'h3

// Output assertion codes that use the single on-time, and the off code
`define HSCCI_OUT_TIMED_A 4'h5
`define HSCCI_OUT_TIMED_B 4'h6
`define HSCCI_OUT_OFF 4'h0

// Widths, status bit positions and reset values
`define HSCCI_TIME_W 14
`define HSCCI_B_STAT_PWR 15
`define HSCCI_B_STAT_SRC1 1
`define HSCCI_B_STAT_SRC2 2
`define HSCCI_WORD_RST 16'h0000
`define HSCCI_VAL_RST 32'h0000_0000
`define HSCCI_TIME_RST 14'h0000

`endif

// ### hdl/hscci_sync.v
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/100ps
module hscci_sync #(
  parameter W = 5
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  genvar g;

  // One pair of flops per bit; the first stage feeds only the second
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      reg meta_ff;
      reg stab_ff;
      always @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_ff <= 1'b0;
          stab_ff <= 1'b0;
        end
        else
        begin
          meta_ff <= async_in[g];
          stab_ff <= meta_ff;
        end
      end
      assign sync_out[g] = stab_ff;
    end
  endgenerate

endmodule

// ### dv/hscci_props.sv
// Port-level assertions for the counter command interface
`timescale 1ns/100ps
`include "hscci_regs.vh"
module hscci_props #(
  parameter DW = 16,
  parameter VW = 32
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Register port
  input wire [3:0] reg_addr,
  input wire [DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [DW-1:0] reg_rdata_ff,
  // Scan and pins
  input wire scan_strobe,
  input wire [1:0] hw_enable,
  input wire field_pwr_ok,
  // Watched outputs
  input wire [1:0] cnt_en_ff,
  input wire [1:0] preset_ff,
  input wire quad_ff,
  input wire [1:0] mode_ff,
  input wire assert_en_ff,
  input wire [DW-1:0] out_mode_ff,
  input wire pwr_lost_ff,
  input wire [VW-1:0] max1_ff
);
  // Shadows of command words 0 and 1
  reg [DW-1:0] w0_ff;
  reg [DW-1:0] w1_ff;
  // Mirror software writes, the stored words are not visible here
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w0_ff <= `HSCCI_WORD_RST;
      w1_ff <= `HSCCI_WORD_RST;
    end
    else if (reg_wr && reg_addr == 4'h0)
      w0_ff <= reg_wdata;
    else if (reg_wr && reg_addr == 4'h1)
      w1_ff <= reg_wdata;
  end
  // Number of nibbles holding a timed output code
  function [2:0] timed_cnt(input [15:0] w);
    integer k;
    reg [3:0] n;
    begin
      timed_cnt = 3'h0;
      for (k = 0; k < 4; k = k + 1)
      begin
        n = w[k*4+:4];
        if (n == `HSCCI_OUT_TIMED_A || n == `HSCCI_OUT_TIMED_B)
          timed_cnt = timed_cnt + 3'h1;
      end
    end
  endfunction
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Scan point carrying a given command code
  sequence s_code(c);
    scan_strobe && w0_ff[15:8] == c;
  endsequence
  // Pin held low long enough to pass the synchroniser
  sequence s_low5(sig);
    (!sig) [*5];
  endsequence
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == '0)
    else $error("read data outside its cycle");
  chk_unmapped_zero: assert property
    (reg_rd && reg_addr[2:1] == 2'b11 |=> reg_rdata_ff == '0)
    else $error("unmapped read not zero");
  chk_sw_preset: assert property (scan_strobe && w0_ff[0] |=> preset_ff[0])
    else $error("software preset missing");
  chk_dis_wins: assert property (scan_strobe && w0_ff[2] |-> ##2 !cnt_en_ff[0])
    else $error("disabled channel still counts");
  chk_pin_gate: assert property (s_low5(hw_enable[0]) |-> !cnt_en_ff[0])
    else $error("pin disable ignored");
  chk_assert_gate: assert property (assert_en_ff |-> mode_ff < 2'h2)
    else $error("assertion in wrong layout");
  chk_one_timed: assert property (timed_cnt(out_mode_ff[15:0]) < 3'h2)
    else $error("two timed outputs");
  chk_cfg_apply: assert property (s_code(`HSCCI_CODE_CFG) |=>
    mode_ff == w1_ff[11:10] && quad_ff == w1_ff[0])
    else $error("configure not applied");
  chk_zero_keep: assert property (s_code(`HSCCI_CODE_LOAD) ##0
    (mode_ff == `HSCCI_MODE_TWO16 && w1_ff == '0) |=> $stable(max1_ff))
    else $error("zero load changed value");
  chk_pwr_flag: assert property (s_low5(field_pwr_ok) |-> pwr_lost_ff)
    else $error("power loss not flagged");
endmodule

// ### dv/hscci_scan_model.sv
// Controller model that paces I/O scan points
`timescale 1ns/100ps
module hscci_scan_model #(
  parameter PERIOD = 8
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Scanning allowed while high
  input wire scan_run,
  // One-cycle scan point
  output reg scan_strobe
);
  // Cycles since last scan; larger PERIOD models a slow controller
  integer cnt_ff;
  // One scan each PERIOD cycles, restarting when halted
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 0;
      scan_strobe <= 1'b0;
    end
    else
    begin
      cnt_ff <= (scan_run && cnt_ff < PERIOD - 1) ? cnt_ff + 1 : 0;
      scan_strobe <= scan_run && cnt_ff == PERIOD - 1;
    end
  end
endmodule

// ### dv/test_hscci_top.sv
// Self-checking bench for the counter command interface
`timescale 1ns/100ps
`include "hscci_regs.vh"
module test_hscci_top;
  // Stimulus, all given a value at time zero
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg scan_run = 1'b0;
  reg plc_run = 1'b0;
  reg bus_ok = 1'b1;
  reg [15:0] ofl_cfg1 = 16'h0401;
  reg [15:0] ofl_cfg2 = 16'h0000;
  reg [1:0] hw_preset = 2'h0;
  reg [1:0] hw_enable = 2'h3;
  reg field_pwr_ok = 1'b1;
  // Count, rate and last values, two channels each
  reg [31:0] dv [0:5];
  // Design outputs
  wire [15:0] reg_rdata_ff, out_mode_ff;
  wire scan_strobe, quad_ff, assert_en_ff, loss_hold_ff;
  wire outputs_off_ff, pwr_lost_ff;
  wire [1:0] cnt_en_ff, preset_ff, mode_ff;
  wire [31:0] max1_ff, set1_ff, max2_ff, set2_ff;
  wire [13:0] on_time_ff, rint1_ff, rint2_ff;
  // Command and response words, bookkeeping
  reg [15:0] cw [0:5];
  reg [15:0] rsp [0:5];
  reg [31:0] seed = 32'hff5a_7ddf;
  reg [31:0] code_tab = 32'h0304_0077;
  reg [63:0] p;
  reg [15:0] r;
  integer n_errors = 0;
  integer checks_done = 0;
  integer cycles = 0;
  integer i;
  integer j;
  hscci_top i_hscci_top (
    .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_ff, .scan_strobe, .plc_run, .bus_ok, .ofl_cfg1, .ofl_cfg2,
    .hw_preset, .hw_enable, .field_pwr_ok, .cnt1_val(dv[0]),
    .cnt2_val(dv[1]), .rate1_val(dv[2]), .rate2_val(dv[3]),
    .last1_val(dv[4]), .last2_val(dv[5]), .cnt_en_ff, .preset_ff,
    .quad_ff, .mode_ff, .assert_en_ff, .loss_hold_ff, .out_mode_ff,
    .outputs_off_ff, .pwr_lost_ff, .max1_ff, .set1_ff, .max2_ff,
    .set2_ff, .on_time_ff, .rint1_ff, .rint2_ff
  );
  hscci_scan_model #(.PERIOD(8)) i_hscci_scan_model (
    .core_clk, .rst_n, .scan_run, .scan_strobe
  );
  // 100 ns period
  always #50 core_clk = ~core_clk;
  // Xorshift source, low half used for words
  function [15:0] rnd();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed[15:0];
    end
  endfunction
  // Later timed nibbles forced off
  function [15:0] first_timed(input [15:0] w);
    integer k;
    reg [3:0] n;
    reg seen;
    begin
      first_timed = w;
      seen = 1'b0;
      for (k = 3; k >= 0; k = k - 1)
      begin
        n = w[k*4+:4];
        if (n == `HSCCI_OUT_TIMED_A || n == `HSCCI_OUT_TIMED_B)
        begin
          if (seen)
            first_timed[k*4+:4] = `HSCCI_OUT_OFF;
          seen = 1'b1;
        end
      end
    end
  endfunction
  // Value pair a read-type code should return
  function [63:0] exp_pair(input [7:0] c, input rate);
    begin
      if (c == `HSCCI_CODE_READ || (c != `HSCCI_CODE_RATE && !rate))
        exp_pair = {dv[1], dv[0]};
      else if (rate)
        exp_pair = {dv[3], dv[2]};
      else
        exp_pair = {dv[5], dv[4]};
    end
  endfunction
  // Compare a response word
  task cmp_word(input string what, input [15:0] exp, input [15:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Compare a control or parameter output
  task cmp_val(input string what, input [31:0] exp, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Verdict and end of run
  task wrap_up;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Hang guard
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  // One-cycle write
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
  endtask
  // One-cycle read, data taken in the cycle after
  task rd(input [3:0] a, output [15:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata_ff;
    end
  endtask
  // Write all words, let one scan pass, read all responses
  task cmd;
    integer k;
    begin
      for (k = 0; k < 6; k = k + 1)
        wr(k[3:0], cw[k]);
      scan_run <= 1'b1;
      k = 0;
      @(posedge core_clk);
      while (scan_strobe !== 1'b1 && k < 40)
      begin
        @(posedge core_clk);
        k = k + 1;
      end
      scan_run <= 1'b0;
      for (k = 0; k < 6; k = k + 1)
        rd(4'h8 + k[3:0], rsp[k]);
    end
  endtask
  // Echo of all six words
  task chk_echo;
    integer k;
    begin
      for (k = 0; k < 6; k = k + 1)
        cmp_word("echo", cw[k], rsp[k]);
    end
  endtask
  // Configure command with random spare words
  task cfg(input [1:0] m, input off, input q, input [15:0] w2);
    begin
      cw[0] = {`HSCCI_CODE_CFG, 8'h22};
      cw[1] = {4'h0, m, 7'h00, 1'b0, off, q};
      cw[2] = w2;
      for (i = 3; i < 6; i = i + 1)
        cw[i] = rnd();
      cmd;
      chk_echo;
    end
  endtask
  // Load command over the current words
  task load;
    begin
      cw[0] = {`HSCCI_CODE_LOAD, 8'h22};
      cmd;
      chk_echo;
    end
  endtask
  // Two 16-bit layout parameters against p and r
  task chk16;
    begin
      cmp_val("max1", {16'h0000, p[15:0]}, max1_ff);
      cmp_val("set1", {16'h0000, p[31:16]}, set1_ff);
      cmp_val("max2", {16'h0000, p[47:32]}, max2_ff);
      cmp_val("set2", {16'h0000, p[63:48]}, set2_ff);
      cmp_val("on time", 32'(r[13:0]), 32'(on_time_ff));
    end
  endtask
  // Main sequence
  initial
  begin
    for (j = 0; j < 6; j = j + 1)
      dv[j] = {rnd(), rnd()};
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    cmp_val("outputs off", 32'h1, 32'(outputs_off_ff));
    rd(4'h8, r);
    cmp_word("reset response", 16'h0000, r);
    rd(4'h6, r);
    cmp_word("unmapped", 16'h0000, r);
    @(posedge core_clk);
    plc_run <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    cmp_val("offline mode", 32'h1, 32'(mode_ff));
    cmp_val("offline quad", 32'h1, 32'(quad_ff));
    // Every layout, assertion on and off, several timed outputs
    for (j = 0; j < 8; j = j + 1)
    begin
      r = rnd();
      cfg(j[1:0], j[2], r[0], {4'h6, r[7:4], 4'h5, r[11:8]});
      cmp_val("mode", 32'(j[1:0]), 32'(mode_ff));
      cmp_val("quad", 32'(r[0]), 32'(quad_ff));
      p[0] = j < 2;
      cmp_val("assert", 32'(p[0]), 32'(assert_en_ff));
      if (j < 2)
        cmp_word("outputs", first_timed(cw[2]), out_mode_ff);
    end
    // Two 16-bit layout, then a load of zeros
    cfg(`HSCCI_MODE_TWO16, 1'b0, 1'b0, 16'h3100);
    for (j = 1; j < 6; j = j + 1)
      cw[j] = rnd() | 16'h0001;
    cw[5] = cw[5] & 16'h3fff;
    p = {cw[4], cw[3], cw[2], cw[1]};
    r = cw[5];
    load;
    chk16;
    cmp_val("outputs on", 32'h0, 32'(outputs_off_ff));
    cmp_val("loss hold", 32'h0, 32'(loss_hold_ff));
    @(posedge core_clk);
    bus_ok <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    cmp_val("loss off", 32'h1, 32'(outputs_off_ff));
    @(posedge core_clk);
    bus_ok <= 1'b1;
    for (j = 1; j < 6; j = j + 1)
      cw[j] = 16'h0000;
    load;
    chk16;
    // One 32-bit layout, high words kept under the maximum
    cfg(`HSCCI_MODE_ONE32, 1'b0, 1'b1, 16'h3100);
    for (j = 1; j < 6; j = j + 1)
      cw[j] = rnd() & (j[0] ? 16'h3fff : 16'h07ff) | 16'h0001;
    load;
    cmp_val("max1 pair", {cw[2], cw[1]}, max1_ff);
    cmp_val("set1 pair", {cw[4], cw[3]}, set1_ff);
    // Rate-sample layout and its intervals
    cfg(`HSCCI_MODE_RATE, 1'b0, 1'b0, 16'h0000);
    cw[1] = rnd() & 16'h3fff | 16'h0001;
    cw[2] = rnd() & 16'h3fff | 16'h0002;
    load;
    cmp_val("interval 1", 32'(cw[1][13:0]), 32'(rint1_ff));
    cmp_val("interval 2", 32'(cw[2][13:0]), 32'(rint2_ff));
    // Read, rate, zero and undefined codes in rate then count mode
    for (j = 0; j < 8; j = j + 1)
    begin
      if (j == 4)
        cfg(`HSCCI_MODE_TWO16, 1'b0, 1'b0, 16'h3100);
      cw[0] = {code_tab[j[1:0]*8+:8], 8'h22};
      cmd;
      p = exp_pair(cw[0][15:8], j < 4);
      for (i = 1; i < 5; i = i + 1)
        cmp_word("value", p[i*16-16+:16], rsp[i]);
      if (cw[0][15:8] == `HSCCI_CODE_READ)
        cmp_word("read echo", cw[0], rsp[0]);
    end
    // Field power lost during a software preset
    @(posedge core_clk);
    field_pwr_ok <= 1'b0;
    repeat (6) @(posedge core_clk);
    cw[0] = {`HSCCI_CODE_READ, 8'h23};
    cmd;
    cmp_word("status", 16'h8000, rsp[5] & 16'h8002);
    // Pin preset after the software one
    @(posedge core_clk);
    field_pwr_ok <= 1'b1;
    hw_preset <= 2'h1;
    repeat (3) @(posedge core_clk);
    hw_preset <= 2'h0;
    cw[0] = {`HSCCI_CODE_READ, 8'h22};
    cmd;
    cmp_word("pin preset", 16'h0002, rsp[5] & 16'h8002);
    // Disable beats enable, then a pin disables alone
    cw[0] = {`HSCCI_CODE_READ, 8'h26};
    cmd;
    cmp_val("disable", 32'h2, 32'(cnt_en_ff));
    @(posedge core_clk);
    hw_enable <= 2'h2;
    cw[0] = {`HSCCI_CODE_READ, 8'h22};
    cmd;
    cmp_val("pin enable", 32'h2, 32'(cnt_en_ff));
    wrap_up;
  end
endmodule
bind hscci_top hscci_props #(.DW(DW), .VW(VW)) i_hscci_props (
  .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata_ff, .scan_strobe, .hw_enable, .field_pwr_ok, .cnt_en_ff,
  .preset_ff, .quad_ff, .mode_ff, .assert_en_ff, .out_mode_ff,
  .pwr_lost_ff, .max1_ff
);
